// >>> hdl/dmm_defines.vh
// Constants for the dual memory move decoder
`ifndef DMM_DEFINES_VH
`define DMM_DEFINES_VH

`define DMM_IW          64
`define DMM_CMP_HI      38
`define DMM_CMP_LO      0
`define DMM_DMI_HI      41
`define DMM_DMI_LO      39
`define DMM_DMM_HI      44
`define DMM_DMM_LO      42
`define DMM_PMI_HI      47
`define DMM_PMI_LO      45
`define DMM_PMM_HI      50
`define DMM_PMM_LO      48
`define DMM_DMR_HI      54
`define DMM_DMR_LO      51
`define DMM_PMR_HI      58
`define DMM_PMR_LO      55
`define DMM_DMD_BIT     59
`define DMM_PMD_BIT     60
`define DMM_CMP_W       39
`define DMM_CMP_NONE    39'h0

`define DMM_MODE_SIMD   0
`define DMM_MODE_BC1    1
`define DMM_MODE_BC9    2
`define DMM_MODE_WD_HI  4
`define DMM_MODE_WD_LO  3
`define DMM_MODE_W      5
`define DMM_MODE_RST    5'h00
`define DMM_MODE_MASK   5'h1F

`define DMM_WD_NORM     2'h0
`define DMM_WD_HALF     2'h1
`define DMM_WD_BYTE     2'h2
`define DMM_K_NORM      3'h1
`define DMM_K_HALF      3'h2
`define DMM_K_BYTE      3'h4
`define DMM_K_BC        3'h0

`define DMM_BC_INDEX    3'h1
`define DMM_DIR_LOAD    1'b0
`define DMM_DIR_STORE   1'b1

`define DMM_AW          7
`define DMM_PG_LO       4
`define DMM_IDX_HI      3
`define DMM_PG_CTRL     3'h0
`define DMM_PG_IREG     3'h1
`define DMM_PG_MREG     3'h2
`define DMM_PG_RREG     3'h3
`define DMM_PG_SREG     3'h4
`define DMM_IX_MODE     4'h0
`define DMM_IX_STAT     4'h1

`endif

// >>> hdl/dmm_decode.v
// Dual memory move decode and execution control
// Functional notes
// - Zero compute field means transfers only
// - Compute runs with both moves, unconditionally
// - Data space uses generator one, program two
// - Address is old index, then index plus modify
// - Only post-modify addressing is decoded
// - Dual-lane: Y uses complementary registers
// - Y address offset 1, 2, 4 by width
// - Broadcast read: offset zero, same value
// - Dual-lane compute writes both element copies
// - Data direction: 0 load, 1 store
// - Program direction: 0 load, 1 store
// - Short form: same moves, no compute
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dmm_defines.vh"

module dmm_decode #(
  parameter DW = 32
) (
  input  wire                  clk_in,
  input  wire                  rst_in,
  input  wire                  instr_valid_in,
  input  wire                  instr_short_in,
  input  wire [`DMM_IW-1:0]    instr_word_in,
  output reg                   cmp_valid_out,
  output reg                   cmp_dual_out,
  output reg  [`DMM_CMP_W-1:0] cmp_field_out,
  input  wire                  cmp_wr_in,
  input  wire [3:0]            cmp_dest_in,
  input  wire [DW-1:0]         cmp_res_x_in,
  input  wire [DW-1:0]         cmp_res_y_in,
  output reg                   dm_req_out,
  output reg                   dm_we_out,
  output reg                   dm_y_en_out,
  output reg  [DW-1:0]         dm_addr_x_out,
  output reg  [DW-1:0]         dm_addr_y_out,
  output reg  [DW-1:0]         dm_wdata_x_out,
  output reg  [DW-1:0]         dm_wdata_y_out,
  input  wire [DW-1:0]         dm_rdata_x_in,
  input  wire [DW-1:0]         dm_rdata_y_in,
  output reg                   pm_req_out,
  output reg                   pm_we_out,
  output reg                   pm_y_en_out,
  output reg  [DW-1:0]         pm_addr_x_out,
  output reg  [DW-1:0]         pm_addr_y_out,
  output reg  [DW-1:0]         pm_wdata_x_out,
  output reg  [DW-1:0]         pm_wdata_y_out,
  input  wire [DW-1:0]         pm_rdata_x_in,
  input  wire [DW-1:0]         pm_rdata_y_in,
  input  wire [`DMM_AW-1:0]    reg_addr_in,
  input  wire [DW-1:0]         reg_wdata_in,
  input  wire                  reg_wr_in,
  input  wire                  reg_rd_in,
  output reg  [DW-1:0]         reg_rdata_out
);

  reg  [DW-1:0]            ireg_r [0:15];
  reg  [DW-1:0]            mreg_r [0:15];
  reg  [DW-1:0]            rreg_r [0:15];
  reg  [DW-1:0]            sreg_r [0:15];
  reg  [`DMM_MODE_W-1:0]   mode_r;
  reg                      dm_ld_r;
  reg                      dm_ld_y_r;
  reg                      dm_ld_bc_r;
  reg  [3:0]               dm_ld_reg_r;
  reg                      pm_ld_r;
  reg                      pm_ld_y_r;
  reg                      pm_ld_bc_r;
  reg  [3:0]               pm_ld_reg_r;
  reg                      cmp_dual_r;

  wire [`DMM_CMP_W-1:0]    cmp_field;
  wire [2:0]               dm_i;
  wire [2:0]               pm_i;
  wire [3:0]               dm_ix;
  wire [3:0]               pm_ix;
  wire [3:0]               dm_mx;
  wire [3:0]               pm_mx;
  wire [3:0]               dm_reg;
  wire [3:0]               pm_reg;
  wire                     dm_dir;
  wire                     pm_dir;
  wire                     simd;
  wire                     has_cmp;
  wire                     dm_bc;
  wire                     pm_bc;
  wire [DW-1:0]            dm_base;
  wire [DW-1:0]            pm_base;
  wire [DW-1:0]            dm_post;
  wire [DW-1:0]            pm_post;
  wire [2:0]               dm_k;
  wire [2:0]               pm_k;
  wire [2:0]               page;
  wire [3:0]               idx;
  reg  [2:0]               width_k;

  assign cmp_field = instr_word_in[`DMM_CMP_HI:`DMM_CMP_LO];
  // Generator one owns indices 0-7, generator two owns 8-15
  assign dm_i   = instr_word_in[`DMM_DMI_HI:`DMM_DMI_LO];
  assign pm_i   = instr_word_in[`DMM_PMI_HI:`DMM_PMI_LO];
  assign dm_ix  = {1'b0, dm_i};
  assign pm_ix  = {1'b1, pm_i};
  assign dm_mx  = {1'b0, instr_word_in[`DMM_DMM_HI:`DMM_DMM_LO]};
  assign pm_mx  = {1'b1, instr_word_in[`DMM_PMM_HI:`DMM_PMM_LO]};
  assign dm_reg = instr_word_in[`DMM_DMR_HI:`DMM_DMR_LO];
  assign pm_reg = instr_word_in[`DMM_PMR_HI:`DMM_PMR_LO];
  assign dm_dir = instr_word_in[`DMM_DMD_BIT];
  assign pm_dir = instr_word_in[`DMM_PMD_BIT];
  assign simd   = mode_r[`DMM_MODE_SIMD];

  // Short form never computes; long form computes unless field is zero
  assign has_cmp = ~instr_short_in && (cmp_field != `DMM_CMP_NONE);

  // Broadcast applies only to reads through index 1 or index 9
  assign dm_bc = (dm_dir == `DMM_DIR_LOAD) && mode_r[`DMM_MODE_BC1] &&
                 (dm_i == `DMM_BC_INDEX);
  assign pm_bc = (pm_dir == `DMM_DIR_LOAD) && mode_r[`DMM_MODE_BC9] &&
                 (pm_i == `DMM_BC_INDEX);

  always @*
  begin
    case (mode_r[`DMM_MODE_WD_HI:`DMM_MODE_WD_LO])
      `DMM_WD_NORM: width_k = `DMM_K_NORM;
      `DMM_WD_HALF: width_k = `DMM_K_HALF;
      `DMM_WD_BYTE: width_k = `DMM_K_BYTE;
      default:      width_k = `DMM_K_NORM;
    endcase
  end

  assign dm_k = dm_bc ? `DMM_K_BC : width_k;
  assign pm_k = pm_bc ? `DMM_K_BC : width_k;

  // Address is the unmodified index; no pre-modify path exists
  assign dm_base = ireg_r[dm_ix];
  assign pm_base = ireg_r[pm_ix];
  assign dm_post = dm_base + mreg_r[dm_mx];
  assign pm_post = pm_base + mreg_r[pm_mx];

  // Memory requests and compute issue, one cycle after the instruction
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dm_req_out     <= 1'b0;
      dm_we_out      <= 1'b0;
      dm_y_en_out    <= 1'b0;
      dm_addr_x_out  <= {DW{1'b0}};
      dm_addr_y_out  <= {DW{1'b0}};
      dm_wdata_x_out <= {DW{1'b0}};
      dm_wdata_y_out <= {DW{1'b0}};
      pm_req_out     <= 1'b0;
      pm_we_out      <= 1'b0;
      pm_y_en_out    <= 1'b0;
      pm_addr_x_out  <= {DW{1'b0}};
      pm_addr_y_out  <= {DW{1'b0}};
      pm_wdata_x_out <= {DW{1'b0}};
      pm_wdata_y_out <= {DW{1'b0}};
      cmp_valid_out  <= 1'b0;
      cmp_dual_out   <= 1'b0;
      cmp_field_out  <= `DMM_CMP_NONE;
    end
    else
    begin
      dm_req_out    <= instr_valid_in;
      pm_req_out    <= instr_valid_in;
      cmp_valid_out <= instr_valid_in && has_cmp;
      if (instr_valid_in)
      begin
        dm_we_out      <= (dm_dir == `DMM_DIR_STORE);
        pm_we_out      <= (pm_dir == `DMM_DIR_STORE);
        dm_y_en_out    <= simd || dm_bc;
        pm_y_en_out    <= simd || pm_bc;
        dm_addr_x_out  <= dm_base;
        pm_addr_x_out  <= pm_base;
        dm_addr_y_out  <= dm_base + {{(DW-3){1'b0}}, dm_k};
        pm_addr_y_out  <= pm_base + {{(DW-3){1'b0}}, pm_k};
        // Stores read the files here, before any writeback lands
        dm_wdata_x_out <= rreg_r[dm_reg];
        dm_wdata_y_out <= sreg_r[dm_reg];
        pm_wdata_x_out <= rreg_r[pm_reg];
        pm_wdata_y_out <= sreg_r[pm_reg];
        cmp_dual_out   <= simd;
        cmp_field_out  <= has_cmp ? cmp_field : `DMM_CMP_NONE;
      end
    end
  end

  // Pending loads, written back when read data returns
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dm_ld_r     <= 1'b0;
      dm_ld_y_r   <= 1'b0;
      dm_ld_bc_r  <= 1'b0;
      dm_ld_reg_r <= 4'h0;
      pm_ld_r     <= 1'b0;
      pm_ld_y_r   <= 1'b0;
      pm_ld_bc_r  <= 1'b0;
      pm_ld_reg_r <= 4'h0;
      cmp_dual_r  <= 1'b0;
    end
    else
    begin
      dm_ld_r    <= instr_valid_in && (dm_dir == `DMM_DIR_LOAD);
      pm_ld_r    <= instr_valid_in && (pm_dir == `DMM_DIR_LOAD);
      dm_ld_y_r  <= simd || dm_bc;
      pm_ld_y_r  <= simd || pm_bc;
      dm_ld_bc_r <= dm_bc;
      pm_ld_bc_r <= pm_bc;
      dm_ld_reg_r <= dm_reg;
      pm_ld_reg_r <= pm_reg;
      cmp_dual_r  <= instr_valid_in ? simd : cmp_dual_r;
    end
  end

  // Register files; loads override compute, program load overrides data load
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_entry
      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          ireg_r[g] <= {DW{1'b0}};
          mreg_r[g] <= {DW{1'b0}};
        end
        else
        begin
          if (instr_valid_in && (dm_ix == g))
            ireg_r[g] <= dm_post;
          else if (instr_valid_in && (pm_ix == g))
            ireg_r[g] <= pm_post;
          else if (reg_wr_in && (page == `DMM_PG_IREG) && (idx == g))
            ireg_r[g] <= reg_wdata_in;
          if (reg_wr_in && (page == `DMM_PG_MREG) && (idx == g))
            mreg_r[g] <= reg_wdata_in;
        end
      end

      always @(posedge clk_in)
      begin
        if (rst_in)
        begin
          rreg_r[g] <= {DW{1'b0}};
          sreg_r[g] <= {DW{1'b0}};
        end
        else
        begin
          if (pm_ld_r && (pm_ld_reg_r == g))
            rreg_r[g] <= pm_rdata_x_in;
          else if (dm_ld_r && (dm_ld_reg_r == g))
            rreg_r[g] <= dm_rdata_x_in;
          else if (cmp_wr_in && (cmp_dest_in == g))
            rreg_r[g] <= cmp_res_x_in;
          else if (reg_wr_in && (page == `DMM_PG_RREG) && (idx == g))
            rreg_r[g] <= reg_wdata_in;
          if (pm_ld_r && pm_ld_y_r && (pm_ld_reg_r == g))
            sreg_r[g] <= pm_ld_bc_r ? pm_rdata_x_in : pm_rdata_y_in;
          else if (dm_ld_r && dm_ld_y_r && (dm_ld_reg_r == g))
            sreg_r[g] <= dm_ld_bc_r ? dm_rdata_x_in : dm_rdata_y_in;
          else if (cmp_wr_in && cmp_dual_r && (cmp_dest_in == g))
            sreg_r[g] <= cmp_res_y_in;
          else if (reg_wr_in && (page == `DMM_PG_SREG) && (idx == g))
            sreg_r[g] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // Software register port
  assign page = reg_addr_in[`DMM_AW-1:`DMM_PG_LO];
  assign idx  = reg_addr_in[`DMM_IDX_HI:0];

  always @(posedge clk_in)
  begin
    if (rst_in)
      mode_r <= `DMM_MODE_RST;
    else if (reg_wr_in && (page == `DMM_PG_CTRL) && (idx == `DMM_IX_MODE))
      mode_r <= reg_wdata_in[`DMM_MODE_W-1:0] & `DMM_MODE_MASK;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= {DW{1'b0}};
    else if (reg_rd_in)
    begin
      case (page)
        `DMM_PG_CTRL:
          if (idx == `DMM_IX_MODE)
            reg_rdata_out <= {{(DW-`DMM_MODE_W){1'b0}}, mode_r};
          else if (idx == `DMM_IX_STAT)
            reg_rdata_out <= {{(DW-3){1'b0}}, cmp_valid_out, pm_ld_r, dm_ld_r};
          else
            reg_rdata_out <= {DW{1'b0}};
        `DMM_PG_IREG: reg_rdata_out <= ireg_r[idx];
        `DMM_PG_MREG: reg_rdata_out <= mreg_r[idx];
        `DMM_PG_RREG: reg_rdata_out <= rreg_r[idx];
        `DMM_PG_SREG: reg_rdata_out <= sreg_r[idx];
        default:      reg_rdata_out <= {DW{1'b0}};
      endcase
    end
    else
      reg_rdata_out <= {DW{1'b0}};
  end

endmodule
`default_nettype wire

// >>> tb/dmm_mem_model.sv
// Memory space model that answers reads in the request cycle
`timescale 1ns/1ps
`default_nettype none
module dmm_mem_model #(
  parameter DW   = 32,
  parameter BASE = 32'h1000_0000
) (
  input  wire logic          clk_in,
  input  wire logic          req_in,
  input  wire logic          y_en_in,
  input  wire logic [DW-1:0] addr_x_in,
  input  wire logic [DW-1:0] addr_y_in,
  output logic      [DW-1:0] rdata_x_out,
  output logic      [DW-1:0] rdata_y_out
);
  logic [DW-1:0] junk_r = {DW{1'b0}};
  // Idle read lines change every cycle so a stale word never passes
  always @(posedge clk_in)
    junk_r <= ~junk_r + 32'h0000_0101;
  assign rdata_x_out = req_in ? addr_x_in + BASE : junk_r;
  assign rdata_y_out = (req_in && y_en_in) ? addr_y_in + BASE : ~junk_r;
endmodule
`default_nettype wire

// >>> tb/dmm_decode_monitor.sv
// Port checker for the dual memory move decoder
`timescale 1ns/1ps
`default_nettype none
module dmm_decode_monitor #(
  parameter DW = 32
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          instr_valid_in,
  input  wire logic          instr_short_in,
  input  wire logic [63:0]   instr_word_in,
  input  wire logic          reg_wr_in,
  input  wire logic [6:0]    reg_addr_in,
  input  wire logic [DW-1:0] reg_wdata_in,
  input  wire logic          cmp_valid_out,
  input  wire logic [38:0]   cmp_field_out,
  input  wire logic          dm_req_out,
  input  wire logic          dm_we_out,
  input  wire logic          dm_y_en_out,
  input  wire logic [DW-1:0] dm_addr_x_out,
  input  wire logic [DW-1:0] dm_addr_y_out,
  input  wire logic          pm_req_out,
  input  wire logic          pm_we_out,
  input  wire logic          pm_y_en_out,
  input  wire logic [DW-1:0] pm_addr_x_out,
  input  wire logic [DW-1:0] pm_addr_y_out
);
  logic [4:0] mode_r;
  logic [2:0] k_w;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Shadow of the mode word, written only through the register port
  always @(posedge clk_in)
    if (rst_in)
      mode_r <= 5'h00;
    else if (reg_wr_in && reg_addr_in == 7'h00)
      mode_r <= reg_wdata_in[4:0];
  assign k_w = (mode_r[4:3] == 2'h1) ? 3'h2 : (mode_r[4:3] == 2'h2) ? 3'h4 : 3'h1;
  sequence issue_s;
    instr_valid_in;
  endsequence
  sequence with_cmp_s;
    issue_s ##0 !instr_short_in && instr_word_in[38:0] != 39'h0;
  endsequence
  req_follow_a: assert property (issue_s |=> dm_req_out && pm_req_out)
    else $error("transfer request missing");
  req_cause_a: assert property (dm_req_out |-> $past(instr_valid_in))
    else $error("request without instruction");
  cmp_issue_a: assert property (with_cmp_s |=> cmp_valid_out &&
    cmp_field_out == $past(instr_word_in[38:0])) else $error("compute not issued");
  cmp_none_a: assert property (issue_s ##0 (instr_short_in ||
    instr_word_in[38:0] == 39'h0) |=> !cmp_valid_out) else $error("spurious compute");
  dm_dir_a: assert property (dm_req_out |-> dm_we_out == $past(instr_word_in[59]))
    else $error("data direction wrong");
  pm_dir_a: assert property (pm_req_out |-> pm_we_out == $past(instr_word_in[60]))
    else $error("program direction wrong");
  y_offset_a: assert property (dm_req_out && mode_r[2:0] == 3'h1 |-> dm_y_en_out &&
    dm_addr_y_out == dm_addr_x_out + k_w) else $error("lane offset wrong");
  bcast_read_a: assert property (dm_req_out && !dm_we_out && mode_r[1] &&
    $past(instr_word_in[41:39]) == 3'h1 |-> dm_y_en_out && dm_addr_y_out == dm_addr_x_out)
    else $error("broadcast address wrong");
  single_lane_a: assert property (dm_req_out && mode_r[2:0] == 3'h0 |-> !dm_y_en_out)
    else $error("lane active in single mode");
  pm_offset_a: assert property (pm_req_out && mode_r[2:0] == 3'h1 |-> pm_y_en_out &&
    pm_addr_y_out == pm_addr_x_out + k_w) else $error("program lane offset wrong");
  pm_bcast_a: assert property (pm_req_out && !pm_we_out && mode_r[2] &&
    $past(instr_word_in[47:45]) == 3'h1 |-> pm_y_en_out && pm_addr_y_out == pm_addr_x_out)
    else $error("program broadcast address wrong");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the dual memory move decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam DW = 32;
  localparam BD = 32'h1000_0000;
  localparam BP = 32'h2000_0000;
  logic          clk_in = 1'b0, rst_in = 1'b1, instr_valid_in = 1'b0, instr_short_in = 1'b0;
  logic [63:0]   instr_word_in = 64'h0;
  logic          cmp_wr_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [3:0]    cmp_dest_in = 4'h0, i;
  logic [6:0]    reg_addr_in = 7'h00;
  logic [DW-1:0] cmp_res_x_in = 32'h0, cmp_res_y_in = 32'h0, reg_wdata_in = 32'h0;
  logic          cmp_valid_out, cmp_dual_out, dm_req_out, dm_we_out, dm_y_en_out;
  logic          pm_req_out, pm_we_out, pm_y_en_out;
  logic [38:0]   cmp_field_out;
  logic [DW-1:0] dm_addr_x_out, dm_addr_y_out, dm_wdata_x_out, dm_wdata_y_out;
  logic [DW-1:0] pm_addr_x_out, pm_addr_y_out, pm_wdata_x_out, pm_wdata_y_out;
  logic [DW-1:0] dm_rdata_x_in, dm_rdata_y_in, pm_rdata_x_in, pm_rdata_y_in, reg_rdata_out;
  logic [DW-1:0] ix [16];
  logic [DW-1:0] r2, r3, kk;
  int            err_total = 0, n_compared = 0;
  always #20 clk_in = ~clk_in;
  dmm_decode #(.DW(DW)) i_dmm_decode (.clk_in(clk_in), .rst_in(rst_in),
    .instr_valid_in(instr_valid_in), .instr_short_in(instr_short_in),
    .instr_word_in(instr_word_in), .cmp_valid_out(cmp_valid_out), .cmp_dual_out(cmp_dual_out),
    .cmp_field_out(cmp_field_out), .cmp_wr_in(cmp_wr_in), .cmp_dest_in(cmp_dest_in),
    .cmp_res_x_in(cmp_res_x_in), .cmp_res_y_in(cmp_res_y_in), .dm_req_out(dm_req_out),
    .dm_we_out(dm_we_out), .dm_y_en_out(dm_y_en_out), .dm_addr_x_out(dm_addr_x_out),
    .dm_addr_y_out(dm_addr_y_out), .dm_wdata_x_out(dm_wdata_x_out),
    .dm_wdata_y_out(dm_wdata_y_out), .dm_rdata_x_in(dm_rdata_x_in),
    .dm_rdata_y_in(dm_rdata_y_in), .pm_req_out(pm_req_out), .pm_we_out(pm_we_out),
    .pm_y_en_out(pm_y_en_out), .pm_addr_x_out(pm_addr_x_out), .pm_addr_y_out(pm_addr_y_out),
    .pm_wdata_x_out(pm_wdata_x_out), .pm_wdata_y_out(pm_wdata_y_out),
    .pm_rdata_x_in(pm_rdata_x_in), .pm_rdata_y_in(pm_rdata_y_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out));
  dmm_mem_model #(.DW(DW), .BASE(BD)) i_dm_mem (.clk_in(clk_in), .req_in(dm_req_out),
    .y_en_in(dm_y_en_out), .addr_x_in(dm_addr_x_out), .addr_y_in(dm_addr_y_out),
    .rdata_x_out(dm_rdata_x_in), .rdata_y_out(dm_rdata_y_in));
  dmm_mem_model #(.DW(DW), .BASE(BP)) i_pm_mem (.clk_in(clk_in), .req_in(pm_req_out),
    .y_en_in(pm_y_en_out), .addr_x_in(pm_addr_x_out), .addr_y_in(pm_addr_y_out),
    .rdata_x_out(pm_rdata_x_in), .rdata_y_out(pm_rdata_y_in));
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  // One instruction, optionally with a compute writeback on the same edge
  task automatic ins(input logic s, input logic cw, input logic [63:0] w);
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    instr_short_in <= s;
    instr_word_in <= w;
    cmp_wr_in <= cw;
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    cmp_wr_in <= 1'b0;
    #1;
  endtask
  function automatic logic [63:0] mk(input logic [38:0] c, input logic [2:0] di, dmo, pi, pmo,
    input logic [3:0] dr, pr, input logic dd, pd);
    return {3'h0, pd, dd, pr, dr, pmo, pi, dmo, di, c};
  endfunction
  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(7'h00, 32'h0);
    rdc(7'h13, 32'h0);
    rdc(7'h7F, 32'h0);
    for (int j = 0; j < 16; j++)
    begin
      i = j[3:0];
      ix[j] = {16'h0, 4'h1, i, 8'h00};
      wr({3'h1, i}, ix[j]);
      wr({3'h2, i}, {28'h0, i} + 32'h1);
      wr({3'h3, i}, {24'h0, 4'hA, i});
      wr({3'h4, i}, {24'h0, 4'hB, i});
    end
    cmp_dest_in <= 4'h5;
    cmp_res_x_in <= 32'hDEAD;
    for (int n = 0; n < 2; n++)
    begin
      ins(1'b0, n == 0, mk(39'h123, 3'h2, 3'h3, 3'h5, 3'h6, 4'h5, 4'h6, 1'b1, 1'b1));
      chk(dm_addr_x_out, ix[2]);
      chk(pm_addr_x_out, ix[13]);
      chk(dm_wdata_x_out, n == 0 ? 32'hA5 : 32'hDEAD);
      chk(pm_wdata_x_out, 32'hA6);
      chk({cmp_valid_out, cmp_field_out}, {1'b1, 39'h123});
      ix[2] = ix[2] + 32'h4;
      ix[13] = ix[13] + 32'hF;
    end
    rdc(7'h12, ix[2]);
    rdc(7'h1D, ix[13]);
    r2 = 32'hA2;
    r3 = 32'hA3;
    for (int d = 0; d < 4; d++)
    begin
      ins(1'b0, 1'b0, mk(39'h0, 3'h4, 3'h0, 3'h2, 3'h1, 4'h2, 4'h3, d[0], d[1]));
      chk({dm_we_out, pm_we_out, cmp_valid_out}, {d[0], d[1], 1'b0});
      if (d[0])
        chk(dm_wdata_x_out, r2);
      if (d[1])
        chk(pm_wdata_x_out, r3);
      r2 = d[0] ? r2 : ix[4] + BD;
      r3 = d[1] ? r3 : ix[10] + BP;
      ix[4] = ix[4] + 32'h1;
      ix[10] = ix[10] + 32'hA;
      rdc(7'h32, r2);
      rdc(7'h33, r3);
    end
    for (int w = 0; w < 4; w++)
    begin
      kk = (w == 3) ? 32'h1 : 32'h1 << w;
      wr(7'h00, {27'h0, w[1:0], 3'h1});
      ins(1'b0, 1'b0, mk(39'h7, 3'h6, 3'h0, 3'h3, 3'h2, 4'h7, 4'h8, 1'b1, 1'b0));
      chk(dm_addr_y_out, ix[6] + kk);
      chk(pm_addr_y_out, ix[11] + kk);
      chk({dm_y_en_out, cmp_dual_out, dm_wdata_y_out}, {2'h3, 32'hB7});
      rdc(7'h48, ix[11] + kk + BP);
      ix[6] = ix[6] + 32'h1;
      ix[11] = ix[11] + 32'hB;
    end
    @(posedge clk_in);
    cmp_dest_in <= 4'h9;
    cmp_res_x_in <= 32'h1111;
    cmp_res_y_in <= 32'h2222;
    cmp_wr_in <= 1'b1;
    @(posedge clk_in);
    cmp_wr_in <= 1'b0;
    rdc(7'h39, 32'h1111);
    rdc(7'h49, 32'h2222);
    for (int b = 0; b < 2; b++)
    begin
      i = b[3:0];
      wr(7'h00, b == 0 ? 32'h2 : 32'h4);
      ins(1'b0, 1'b0, mk(39'h0, 3'h1, 3'h0, 3'h1, 3'h0, 4'hA, 4'hB, 1'b0, 1'b0));
      chk({dm_y_en_out, pm_y_en_out}, {b == 0, b == 1});
      chk(b == 0 ? dm_addr_y_out : pm_addr_y_out, b == 0 ? ix[1] : ix[9]);
      rdc({3'h3, 4'hA + i}, b == 0 ? ix[1] + BD : ix[9] + BP);
      rdc({3'h4, 4'hA + i}, b == 0 ? ix[1] + BD : ix[9] + BP);
      ix[1] = ix[1] + 32'h1;
      ix[9] = ix[9] + 32'h9;
    end
    wr(7'h00, 32'h0);
    ins(1'b1, 1'b0, mk(39'h55, 3'h0, 3'h0, 3'h0, 3'h0, 4'h0, 4'h1, 1'b1, 1'b1));
    chk({cmp_valid_out, cmp_field_out, dm_req_out, pm_req_out}, {40'h0, 2'h3});
    chk({dm_addr_x_out, pm_addr_x_out}, {ix[0], ix[8]});
    chk({cmp_dual_out, dm_y_en_out, pm_y_en_out, dm_wdata_y_out}, {3'h0, 32'hB0});
    chk(pm_wdata_y_out, 32'hB1);
    stop_test();
  end
endmodule
bind dmm_decode dmm_decode_monitor #(.DW(DW)) i_dmm_decode_monitor (.clk_in(clk_in),
  .rst_in(rst_in), .instr_valid_in(instr_valid_in), .instr_short_in(instr_short_in),
  .instr_word_in(instr_word_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .cmp_valid_out(cmp_valid_out), .cmp_field_out(cmp_field_out),
  .dm_req_out(dm_req_out), .dm_we_out(dm_we_out), .dm_y_en_out(dm_y_en_out),
  .dm_addr_x_out(dm_addr_x_out), .dm_addr_y_out(dm_addr_y_out), .pm_req_out(pm_req_out),
  .pm_we_out(pm_we_out), .pm_y_en_out(pm_y_en_out), .pm_addr_x_out(pm_addr_x_out),
  .pm_addr_y_out(pm_addr_y_out));
`default_nettype wire
